// file: hw/strap_cfg_regs.svh
`ifndef STRAP_CFG_REGS_SVH
`define STRAP_CFG_REGS_SVH
// =====================================================
// interface mode encodings of the uplink
`define UPLINK_MODE_MII 2'h0
`define UPLINK_MODE_RMII 2'h1
`define UPLINK_MODE_GMII 2'h2
`define UPLINK_MODE_RGMII 2'h3
// rmii clock select register position
`define RMII_CLK_REG_ADDR 8'h56
`define RMII_CLK_REG_BIT 7
// clock rates
`define SYS_CLK_HZ 20000000
// strap defaults when a pin is left floating
`define STRAP_ROLE_DEFAULT 1'h1
`define STRAP_REFOUT_DEFAULT 1'h1
`define STRAP_PLL_DEFAULT 1'h1
`define STRAP_SPEED_DEFAULT 1'h1
`define STRAP_BUS_DEFAULT 1'h0
`endif

// file: hw/strap_cfg_pkg.sv
package strap_cfg_pkg;
  typedef enum logic {BUS_SPI, BUS_MDIO} mgmt_bus_t;
  typedef enum logic {ROLE_PHY, ROLE_MAC} uplink_role_t;
  typedef enum {ST_RESET, ST_RUN} phase_t;
endpackage : strap_cfg_pkg

// file: hw/strap_cfg_if.sv
// =====================================================
// latched strap values shared between loader and pin logic
interface strap_cfg_if;
  logic uplinkRole;
  logic refoutEnable;
  logic pllSource;
  logic uplinkSpeed;
  logic serialBus;
  logic running;
  modport loader (output uplinkRole, refoutEnable, pllSource, uplinkSpeed,
    serialBus, running);
  modport user (input uplinkRole, refoutEnable, pllSource, uplinkSpeed,
    serialBus, running);
endinterface : strap_cfg_if

// file: hw/strap_latch.sv
`include "strap_cfg_regs.svh"
// =====================================================
// samples the straps while reset holds and on the first edge after release, then freezes them
module strap_latch (
  input wire logic sysClk, // system clock
  input wire logic sysRst, // synchronous reset
  input wire logic [4:0] strapIn, // role, refout, pll, speed, bus
  strap_cfg_if.loader cfg // latched values
);
  strap_cfg_pkg::phase_t phaseReg;

  // phase tracking
  always_ff @(posedge sysClk) begin
    if (sysRst) begin
      phaseReg <= strap_cfg_pkg::ST_RESET;
    end else begin
      case (phaseReg)
        strap_cfg_pkg::ST_RESET: phaseReg <= strap_cfg_pkg::ST_RUN;
        strap_cfg_pkg::ST_RUN: phaseReg <= strap_cfg_pkg::ST_RUN;
        default: phaseReg <= strap_cfg_pkg::ST_RESET;
      endcase
    end
  end

  // sample during reset, hold afterwards
  always_ff @(posedge sysClk) begin
    if (phaseReg == strap_cfg_pkg::ST_RESET) begin
      cfg.uplinkRole <= strapIn[4];
      cfg.refoutEnable <= strapIn[3];
      cfg.pllSource <= strapIn[2];
      cfg.uplinkSpeed <= strapIn[1];
      cfg.serialBus <= strapIn[0];
    end
  end

  assign cfg.running = (phaseReg == strap_cfg_pkg::ST_RUN);
endmodule : strap_latch

// file: hw/strap_and_serial_select_config.sv
// Functional notes
// - in GMII or MII, role strap high is MAC, low is PHY.
// - GMII PHY role drives carrier-sense and collision pins.
// - MII PHY role drives carrier, collision, rx and tx clocks.
// - RMII role high: clock mode, 50 MHz reference out on rx clock.
// - RMII role low: reference taken from tx clock input.
// - register 0x56 bit 7 can also choose internal or external clock.
// - refout strap high enables 25 MHz output, low disables it.
// - RMII normal mode, pll strap low uses tx clock as switch source.
// - GMII/RGMII speed strap high gives 1 Gbps; register can override.
// - serial-out strap low is SPI, high is MDC/MDIO; board pulls it.
// - data pin input only in SPI, bidirectional in MDC/MDIO.
// - SPI read data leaves on the serial-out pin.
// - chip select high deselects and floats serial-out.
// - falling chip select starts a new SPI transfer.
// - high synchronous reset resets everything.
// - straps sampled during reset.
// - strap pins are inputs in reset, the four LED pins driven outputs afterwards.
`include "strap_cfg_regs.svh"
module strap_and_serial_select_config (
  input wire logic sysClk, // 20 MHz system clock
  input wire logic sysRst, // synchronous reset, active high
  input wire logic [1:0] uplinkMode, // interface mode select
  input wire logic uplinkRoleStrap, // role strap pin level
  input wire logic refoutEnableStrap, // refout strap pin level
  input wire logic pllSourceStrap, // pll strap pin level
  input wire logic uplinkSpeedStrap, // speed strap pin level
  input wire logic serialOutBusStrap, // bus select strap level
  input wire logic [3:0] ledValue, // indicator values after reset
  input wire logic rmiiClkOvrValid, // 0x56 bit 7 written
  input wire logic rmiiClkOvr, // 0x56 bit 7 value, 1 internal
  input wire logic speedOvrValid, // speed register written
  input wire logic speedOvr, // speed register value, 1 gigabit
  input wire logic mgmtChipSelectN, // spi chip select, active low
  input wire logic spiReadData, // read data bit to shift out
  input wire logic mdioOutData, // mdio data to drive
  input wire logic mdioOutActive, // mdio read turnaround drive
  output logic [3:0] ledOut, // strap pins as outputs
  output logic [3:0] ledOe, // strap pin output enables
  output logic serialOut, // serial-out data
  output logic serialOutOe, // serial-out enable
  output logic mdioOut, // data pin output value
  output logic mdioOe, // data pin output enable
  output logic spiStart, // one-cycle pulse, transfer start
  output logic spiSelected, // chip selected in spi mode
  output logic uplinkMacRole, // 1 mac role, 0 phy role
  output logic crsColOe, // carrier and collision driven
  output logic miiClocksOe, // rx/tx clock pins driven in mii
  output logic rmiiClockMode, // 1 internal 50 MHz reference
  output logic rmiiRefOutEn, // drive 50 MHz on rx clock pin
  output logic pllFromTxClock, // switch clock from tx clock input
  output logic refClockOutEn, // 25 MHz output enable
  output logic uplinkGigabit, // 1 gigabit, 0 10/100
  output logic mdioBusMode // 1 mdc/mdio, 0 spi
);
  // =====================================================
  // strap capture
  strap_cfg_if cfg ();
  logic csPrevReg;
  logic rmiiOvrValidReg;
  logic rmiiOvrReg;
  logic speedOvrValidReg;
  logic speedOvrReg;
  logic isMii;
  logic isRmii;
  logic isGmiiFamily;
  logic gigSelect;
  logic phyRole;
  logic cfgHold;
  logic rmiiClockInt;
  logic rmiiInternal;
  logic spiMode;

  strap_latch latchInst (
    .sysClk(sysClk),
    .sysRst(sysRst),
    .strapIn({uplinkRoleStrap, refoutEnableStrap, pllSourceStrap,
      uplinkSpeedStrap, serialOutBusStrap}),
    .cfg(cfg)
  );

  // =====================================================
  // mode decode helpers
  // modes that carry separate carrier and collision pins
  function automatic logic mode_has_crs_col(input logic [1:0] mode);
    mode_has_crs_col = (mode == `UPLINK_MODE_MII)
      || (mode == `UPLINK_MODE_GMII);
  endfunction : mode_has_crs_col

  // modes whose uplink can run at the gigabit rate
  function automatic logic mode_is_gig_family(input logic [1:0] mode);
    mode_is_gig_family = (mode == `UPLINK_MODE_GMII)
      || (mode == `UPLINK_MODE_RGMII);
  endfunction : mode_is_gig_family

  // a written register value wins over the latched strap
  // shared by the rmii clock choice and the speed choice
  function automatic logic pick_override(input logic ovrValid,
    input logic ovrValue, input logic strapValue);
    pick_override = ovrValid ? ovrValue : strapValue;
  endfunction : pick_override

  // mode decode
  assign isMii = (uplinkMode == `UPLINK_MODE_MII);
  assign isRmii = (uplinkMode == `UPLINK_MODE_RMII);
  assign isGmiiFamily = mode_is_gig_family(uplinkMode);
  assign spiMode = (cfg.serialBus == 1'h0);
  assign phyRole = !cfg.uplinkRole;
  // outputs rest at reset values until the straps are frozen,
  // so nothing downstream acts on a half-sampled strap set
  assign cfgHold = sysRst || !cfg.running;
  // sticky overrides replace the strap once written
  assign rmiiInternal = pick_override(rmiiOvrValidReg, rmiiOvrReg,
    cfg.uplinkRole);
  assign gigSelect = pick_override(speedOvrValidReg, speedOvrReg,
    cfg.uplinkSpeed);
  // rmii clock mode, used by both the mode flag and the ref output
  assign rmiiClockInt = isRmii && rmiiInternal;

  // =====================================================
  // register overrides, cleared by reset
  // rmii clock source override
  // a write stays in force until the next reset
  always_ff @(posedge sysClk) begin
    if (sysRst) begin
      rmiiOvrValidReg <= 1'h0;
      rmiiOvrReg <= 1'h0;
    end else if (rmiiClkOvrValid) begin
      rmiiOvrValidReg <= 1'h1;
      rmiiOvrReg <= rmiiClkOvr;
    end
  end

  // uplink speed override
  // ignored downstream outside the gigabit-capable modes
  always_ff @(posedge sysClk) begin
    if (sysRst) begin
      speedOvrValidReg <= 1'h0;
      speedOvrReg <= 1'h0;
    end else if (speedOvrValid) begin
      speedOvrValidReg <= 1'h1;
      speedOvrReg <= speedOvr;
    end
  end

  // =====================================================
  // uplink role and pin direction outputs
  // role reported to the port logic
  // mac is the default while the straps are not yet frozen
  always_ff @(posedge sysClk) begin
    if (cfgHold) begin
      uplinkMacRole <= `STRAP_ROLE_DEFAULT;
    end else begin
      uplinkMacRole <= cfg.uplinkRole;
    end
  end

  // carrier and collision pins turn into outputs in mii and gmii phy role
  // kept as inputs in the other modes to avoid a drive fight
  always_ff @(posedge sysClk) begin
    if (cfgHold) begin
      crsColOe <= 1'h0;
    end else begin
      crsColOe <= mode_has_crs_col(uplinkMode) && phyRole;
    end
  end

  // mii phy role also drives both clock pins
  // in mac role the attached phy sources those clocks
  always_ff @(posedge sysClk) begin
    if (cfgHold) begin
      miiClocksOe <= 1'h0;
    end else begin
      miiClocksOe <= isMii && phyRole;
    end
  end

  // =====================================================
  // uplink clocking
  // rmii clock mode and its 50 MHz reference output
  // both follow the same choice, strap or register
  always_ff @(posedge sysClk) begin
    if (cfgHold) begin
      rmiiClockMode <= 1'h0;
      rmiiRefOutEn <= 1'h0;
    end else begin
      rmiiClockMode <= rmiiClockInt;
      rmiiRefOutEn <= rmiiClockInt;
    end
  end

  // normal mode: tx clock input carries the reference
  // pll strap high keeps the crystal if that input is jittery
  always_ff @(posedge sysClk) begin
    if (cfgHold) begin
      pllFromTxClock <= 1'h0;
    end else begin
      pllFromTxClock <= isRmii && !rmiiInternal
        && !cfg.pllSource;
    end
  end

  // 25 MHz reference output enable
  // disabling it saves power when nothing uses the clock
  always_ff @(posedge sysClk) begin
    if (cfgHold) begin
      refClockOutEn <= 1'h0;
    end else begin
      refClockOutEn <= cfg.refoutEnable;
    end
  end

  // gigabit select
  // forced low in mii and rmii, which have no gigabit rate
  always_ff @(posedge sysClk) begin
    if (cfgHold) begin
      uplinkGigabit <= 1'h0;
    end else begin
      uplinkGigabit <= isGmiiFamily && gigSelect;
    end
  end

  // =====================================================
  // management bus
  // bus choice reported to the serial front end
  // reads spi until the strap is frozen
  always_ff @(posedge sysClk) begin
    if (cfgHold) begin
      mdioBusMode <= 1'h0;
    end else begin
      mdioBusMode <= !spiMode;
    end
  end

  // =====================================================
  // strap pins become indicator outputs after reset
  // pins stay inputs through reset so the board pulls set the straps
  for (genvar ledIdx = 0; ledIdx < 4; ledIdx++) begin : g_led_pin
    always_ff @(posedge sysClk) begin
      if (cfgHold) begin
        ledOut[ledIdx] <= 1'h0;
        ledOe[ledIdx] <= 1'h0;
      end else begin
        ledOut[ledIdx] <= ledValue[ledIdx];
        ledOe[ledIdx] <= 1'h1;
      end
    end
  end

  // =====================================================
  // chip select edge detection
  // previous level resets to the idle high level, no false edge
  always_ff @(posedge sysClk) begin
    if (sysRst) begin
      csPrevReg <= 1'h1;
    end else begin
      csPrevReg <= mgmtChipSelectN;
    end
  end

  // start pulse on a falling select in spi mode only
  // one cycle wide, since the previous level follows the pin
  always_ff @(posedge sysClk) begin
    if (sysRst) begin
      spiStart <= 1'h0;
    end else begin
      spiStart <= cfg.running && spiMode && csPrevReg
        && !mgmtChipSelectN;
    end
  end

  // selected level while the select is held low
  // never set in mdio mode, where the select has no meaning
  always_ff @(posedge sysClk) begin
    if (sysRst) begin
      spiSelected <= 1'h0;
    end else begin
      spiSelected <= cfg.running && spiMode && !mgmtChipSelectN;
    end
  end

  // =====================================================
  // serial-out and data pin drivers
  // serial-out floats whenever deselected or not in spi mode
  // the pin doubles as the bus strap, so it stays off in reset
  always_ff @(posedge sysClk) begin
    if (cfgHold) begin
      serialOut <= 1'h0;
      serialOutOe <= 1'h0;
    end else begin
      serialOut <= spiReadData;
      serialOutOe <= spiMode && !mgmtChipSelectN;
    end
  end

  // data pin is an input in spi mode, two-way in mdio mode
  // the mdio side asks for drive only during its read phase
  always_ff @(posedge sysClk) begin
    if (cfgHold) begin
      mdioOut <= 1'h0;
      mdioOe <= 1'h0;
    end else begin
      mdioOut <= mdioOutData;
      mdioOe <= !spiMode && mdioOutActive;
    end
  end
endmodule : strap_and_serial_select_config

// file: dv/strap_cfg_monitor.sv
`include "strap_cfg_regs.svh"
// =====
// port checker of the strap loader
module strap_cfg_monitor (
  input wire logic sysClk, // clock
  input wire logic sysRst, // reset
  input wire logic [1:0] uplinkMode, // mode
  input wire logic refoutEnableStrap, // strap
  input wire logic serialOutBusStrap, // strap
  input wire logic mgmtChipSelectN, // select
  input wire logic speedOvrValid, // write
  input wire logic speedOvr, // value
  input wire logic spiStart, // pulse
  input wire logic serialOutOe, // enable
  input wire logic mdioOe, // enable
  input wire logic mdioBusMode, // bus
  input wire logic uplinkMacRole, // role
  input wire logic crsColOe, // driven
  input wire logic rmiiClockMode, // clock
  input wire logic rmiiRefOutEn, // out
  input wire logic refClockOutEn, // refout
  input wire logic uplinkGigabit // speed
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] runCnt;
  logic prevRst, latRef, latBus;
  wire logic ok = runCnt == 2'h3;
  // cycles since release and strap copy
  always_ff @(posedge sysClk) begin
    prevRst <= sysRst;
    runCnt <= sysRst ? 2'h0 : runCnt + {1'h0, runCnt != 2'h3};
    if (sysRst || prevRst) begin
      latRef <= refoutEnableStrap;
      latBus <= serialOutBusStrap;
    end
  end
  default clocking cb @(posedge sysClk); endclocking
  default disable iff (sysRst);
  // =====
  // assertions
  property p_pulse; spiStart |=> !spiStart; endproperty
  a_pulse: assert property (p_pulse)
    else $error("spiStart wider than one cycle");
  property p_cause; spiStart |-> !mdioBusMode && !$past(mgmtChipSelectN);
  endproperty
  a_cause: assert property (p_cause)
    else $error("spiStart without select");
  property p_float; mgmtChipSelectN |=> !serialOutOe; endproperty
  a_float: assert property (p_float)
    else $error("serialOut driven while deselected");
  property p_mdio; !mdioBusMode |-> !mdioOe; endproperty
  a_mdio: assert property (p_mdio)
    else $error("data pin driven in spi mode");
  property p_so; serialOutOe |-> !mdioBusMode; endproperty
  a_so: assert property (p_so)
    else $error("serialOut driven in mdio mode");
  property p_ref; ok |-> refClockOutEn == latRef; endproperty
  a_ref: assert property (p_ref)
    else $error("refout enable differs from strap");
  property p_bus; ok |-> mdioBusMode == latBus; endproperty
  a_bus: assert property (p_bus)
    else $error("bus mode differs from strap");
  property p_rref;
    ok |-> rmiiRefOutEn == rmiiClockMode
      && (uplinkMode == `UPLINK_MODE_RMII || !rmiiClockMode);
  endproperty
  a_rref: assert property (p_rref)
    else $error("rmii reference out differs from clock mode");
  property p_crs;
    ok && uplinkMode == `UPLINK_MODE_GMII |-> crsColOe == !uplinkMacRole;
  endproperty
  a_crs: assert property (p_crs)
    else $error("carrier pins enable wrong");
  property p_spd;
    ok && speedOvrValid && uplinkMode[1] |=> ##1
      uplinkGigabit == $past(speedOvr, 2);
  endproperty
  a_spd: assert property (p_spd)
    else $error("speed override not applied");
  c_start: cover property (spiStart);
  c_mdio: cover property (ok && mdioOe);
  c_spd: cover property (ok && speedOvrValid);
endmodule : strap_cfg_monitor

// file: dv/strap_board_model.sv
// =====
// board pulls on the strap pins, overdriven once pins become outputs
module strap_board_model (
  input wire logic [4:0] pullLevel, // bit0 role to bit4 bus
  input wire logic [3:0] ledOut, // led pin values
  input wire logic [3:0] ledOe, // led pin enables
  input wire logic serialOut, // serial-out value
  input wire logic serialOutOe, // serial-out enable
  output logic [4:0] strapPin // resolved pin levels
);
  timeunit 1ns;
  timeprecision 1ns;
  // pull level unless the device drives the pin
  always_comb begin
    strapPin[4] = serialOutOe ? serialOut : pullLevel[4];
    for (int i = 0; i < 4; i++) begin
      strapPin[i] = ledOe[i] ? ledOut[i] : pullLevel[i];
    end
  end
endmodule : strap_board_model

// file: dv/tb_strap_and_serial_select_config.sv
`include "strap_cfg_regs.svh"
// =====
// strap loader bench
module tb_strap_and_serial_select_config;
  timeunit 1ns;
  timeprecision 1ns;
  logic sysClk = 1'h0, sysRst = 1'h1, rmiiClkOvrValid = 1'h0;
  logic [1:0] uplinkMode = 2'h0;
  logic [4:0] pullLevel = 5'h00, strapPin;
  logic [3:0] ledValue = 4'hA, ledOut, ledOe;
  logic rmiiClkOvr = 1'h0, speedOvrValid = 1'h0, speedOvr = 1'h0;
  logic mgmtChipSelectN = 1'h1, spiReadData = 1'h1, mdioOutData = 1'h0;
  logic mdioOutActive = 1'h0, serialOut, serialOutOe, mdioOut, mdioOe;
  logic spiStart, spiSelected, uplinkMacRole, crsColOe, miiClocksOe;
  logic rmiiClockMode, rmiiRefOutEn, pllFromTxClock, refClockOutEn;
  logic uplinkGigabit, mdioBusMode;
  int failures = 0, total_checks = 0;
  strap_and_serial_select_config strap_and_serial_select_config_inst (
    .sysClk, .sysRst, .uplinkMode, .uplinkRoleStrap(strapPin[0]),
    .refoutEnableStrap(strapPin[1]), .pllSourceStrap(strapPin[2]),
    .uplinkSpeedStrap(strapPin[3]), .serialOutBusStrap(strapPin[4]),
    .ledValue, .rmiiClkOvrValid, .rmiiClkOvr, .speedOvrValid, .speedOvr,
    .mgmtChipSelectN, .spiReadData, .mdioOutData, .mdioOutActive, .ledOut,
    .ledOe, .serialOut, .serialOutOe, .mdioOut, .mdioOe, .spiStart,
    .spiSelected, .uplinkMacRole, .crsColOe, .miiClocksOe, .rmiiClockMode,
    .rmiiRefOutEn, .pllFromTxClock, .refClockOutEn, .uplinkGigabit,
    .mdioBusMode);
  strap_board_model strap_board_model_inst (.pullLevel, .ledOut, .ledOe,
    .serialOut, .serialOutOe, .strapPin);
  // compare and count
  task automatic chk(string name, logic [3:0] seen, logic [3:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // wait edges, then step off the edge
  task automatic tick(int n);
    repeat (n) @(posedge sysClk);
    #5;
  endtask : tick
  // summary and end of run
  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // clock
  initial forever #25 sysClk = ~sysClk;
  // watchdog
  initial begin
    repeat (20000) @(posedge sysClk);
    failures++;
    give_verdict();
  end
  // every mode against every strap pattern
  initial begin
    logic rm, mp, st;
    tick(20);
    for (int i = 0; i < 128; i++) begin
      sysRst = 1'h1;
      {uplinkMode, pullLevel} = i[6:0];
      ledValue = ~i[3:0];
      spiReadData = i[2];
      mdioOutData = !i[2];
      rm = uplinkMode == `UPLINK_MODE_RMII;
      mp = uplinkMode == `UPLINK_MODE_MII || uplinkMode == `UPLINK_MODE_GMII;
      tick(2);
      chk("rstOut", {spiStart, serialOutOe, mdioOe, uplinkMacRole},
        4'h1);
      chk("rstLedOe", ledOe, 4'h0);
      sysRst = 1'h0;
      tick(4);
      chk("refClk", refClockOutEn, pullLevel[1]);
      chk("bus", mdioBusMode, pullLevel[4]);
      chk("ledOe", ledOe, 4'hF);
      chk("ledOut", ledOut, ledValue);
      chk("pll", pllFromTxClock, rm && !pullLevel[0] && !pullLevel[2]);
      if (rm) chk("rmiiClk", {rmiiRefOutEn, rmiiClockMode},
        {2{pullLevel[0]}});
      if (mp) chk("role", uplinkMacRole, pullLevel[0]);
      chk("crsCol", crsColOe, mp && !pullLevel[0]);
      chk("miiClk", miiClocksOe, !uplinkMode && !pullLevel[0]);
      if (uplinkMode[1]) chk("gig", uplinkGigabit, pullLevel[3]);
      // host paces select and data at the 20 MHz bench clock
      mgmtChipSelectN = 1'h0;
      mdioOutActive = 1'h1;
      st = 1'h0;
      repeat (3) begin
        tick(1);
        st |= spiStart;
      end
      chk("start", st, !pullLevel[4]);
      chk("sel", {spiSelected, serialOutOe, mdioOe},
        pullLevel[4] ? 3'h1 : 3'h6);
      chk("data", {serialOut, mdioOut}, {spiReadData, mdioOutData});
      mgmtChipSelectN = 1'h1;
      mdioOutActive = 1'h0;
      rmiiClkOvr = !pullLevel[0];
      speedOvr = !pullLevel[3];
      rmiiClkOvrValid = 1'h1;
      speedOvrValid = 1'h1;
      tick(1);
      rmiiClkOvrValid = 1'h0;
      speedOvrValid = 1'h0;
      tick(2);
      chk("float", serialOutOe, 4'h0);
      if (rm) chk("rmiiOvr", {rmiiRefOutEn, rmiiClockMode},
        {2{!pullLevel[0]}});
      if (uplinkMode[1]) chk("gigOvr", uplinkGigabit, !pullLevel[3]);
      chk("hold", refClockOutEn, pullLevel[1]);
    end
    give_verdict();
  end
endmodule : tb_strap_and_serial_select_config

bind strap_and_serial_select_config strap_cfg_monitor strap_cfg_monitor_inst (
  .sysClk, .sysRst, .uplinkMode, .refoutEnableStrap, .serialOutBusStrap,
  .mgmtChipSelectN, .speedOvrValid, .speedOvr, .spiStart, .serialOutOe,
  .mdioOe, .mdioBusMode, .uplinkMacRole, .crsColOe, .rmiiClockMode,
  .rmiiRefOutEn, .refClockOutEn, .uplinkGigabit);
